// File: rtl/rvs_map.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef RVS_MAP_SVH
`define RVS_MAP_SVH

`define RVS_ADDR_OPTION 8'h94
`define RVS_ADDR_INTERRUPT_FLAG_REG 8'h95
`define RVS_ADDR_SOFTWARE_COMMAND 8'h97
`define RVS_ADDR_LVDCTL 8'hBF
`define RVS_ADDR_AUXILIARY_CTRL_2 8'hF7
`define RVS_ADDR_AUXILIARY_CTRL_1 8'hF8

`define RVS_BIT_WDT_PSC_HI 5
`define RVS_BIT_WDT_PSC_LO 4
`define RVS_BIT_DET_FLAG 7
`define RVS_BIT_DET_IE 7
`define RVS_BIT_DET_RES 6
`define RVS_BIT_DET_SEL_HI 3
`define RVS_BIT_DET_SEL_LO 1
`define RVS_BIT_PULL_EN 0
`define RVS_BIT_WATCHDOG_RESET_CONTROL_HI 7
`define RVS_BIT_WATCHDOG_RESET_CONTROL_LO 6
`define RVS_BIT_POWER_SAVING_BIT 5
`define RVS_BIT_WDT_CLR 7
`define RVS_BIT_UVR_DIS 3
`define RVS_BIT_CFG_PIN_DIS 6
`define RVS_BIT_CFG_UVR_HI 5
`define RVS_BIT_CFG_UVR_LO 3

`define RVS_CMD_SW_RESET 8'h56
`define RVS_CMD_DET_CLEAR 8'h7F
`define RVS_BYTE_ZERO 8'h00

`define RVS_CFG_FIRST_ADDR 16'h7FFA
`define RVS_CFG_HIGH_ADDR 16'h7FFF
`define RVS_CFG_BYTES 3'h6

`define RVS_CLK_MHZ 200
`define RVS_WARMUP_MS 40
`define RVS_SRC_HZ 80000
`define RVS_WDT_MAX_MS 400
`define RVS_PIN_LOW_TICKS 2'h2
`define RVS_HOLD_CYCLES 16

`endif

// File: rtl/rvs_pkg.sv
// Types shared by the reset and voltage supervisor.
package rvs_pkg;

  typedef enum logic [3:0] {
    RVS_WARM = 4'b0001,
    RVS_LOAD = 4'b0010,
    RVS_RUN = 4'b0100,
    RVS_HOLD = 4'b1000
  } rvs_state_t;

  typedef enum logic [2:0] {
    RVS_FAST = 3'h0,
    RVS_SLOW = 3'h1,
    RVS_IDLE = 3'h2,
    RVS_HALT = 3'h3,
    RVS_STOP = 3'h4
  } rvs_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rvs_sfr_req_t;

  typedef struct packed {
    logic uv_reset_enable;
    logic por_only;
    logic detector_enable;
    logic [2:0] uv_reset_level;
    logic [2:0] detect_level;
  } rvs_uv_ctrl_t;

endpackage : rvs_pkg

// File: rtl/rvs_top.sv
// Reset sequencer, watchdog and undervoltage supervision for the core.
//
// Behaviour
// - Power-saving bit set turns undervoltage reset off in idle, halt, stop.
// - Reset-disable bit 0 enables undervoltage reset; 1 disables it always.
// - Config 3-bit level picks eight undervoltage reset trip points.
// - Detect select field picks one of eight detector thresholds.
// - Detect interrupt needs both local and extended enables set.
// - Detector comparison result is readable in the detect control register.
// - Hardware sets detect flag; writing 7Fh to flag register clears it.
// - Pull supply enable clears only on divided-by-16 or slow clock.
// - After power-on the device holds reset for 40 ms warm-up.
// - After warm-up, config word loads from last six program bytes.
// - Pin reset is active low, recognised after two slow oscillator periods.
// - Config pin reset bit 0 honours pin reset; 1 ignores it.
// - Writing 56h to the software command register resets the device.
// - Every reset source returns all registers to their defaults.
// - Watchdog counts slow internal oscillator periods, not system clock.
// - Watchdog period field selects 400, 200, 100 or 50 ms.
// - Watchdog control: 0x off, 10 fast/slow only, 11 always.
// - Watchdog counter clears on any reset and on the clear bit.
// - Hardware returns the watchdog clear bit to zero next cycle.
`include "rvs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rvs_top
  import rvs_pkg::*;
#(
  parameter int WARMUP_CYCLES = `RVS_WARMUP_MS * 1000 * `RVS_CLK_MHZ,
  parameter int WDT_MAX_TICKS = `RVS_WDT_MAX_MS * (`RVS_SRC_HZ / 1000)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire rvs_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic [15:0] flash_addr,
  output logic flash_rd,
  input wire logic [7:0] flash_rdata,
  input wire logic pin_reset_n,
  input wire logic slow_internal_oscillator,
  input wire logic uv_reset_below,
  input wire logic detect_below,
  input wire rvs_mode_t power_mode,
  input wire logic sysclk_slow_ok,
  input wire logic extended_detect_irq_enable,
  output logic sys_rst_n,
  output logic detect_irq,
  output logic internal_pull_supply_enable,
  output rvs_uv_ctrl_t uv_ctrl,
  output logic [7:0] config_word_high
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  rvs_state_t state_r;
  logic [31:0] seq_cnt_r;
  logic [2:0] load_cnt_r;
  logic load_rd_r;
  logic [15:0] load_addr_r;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic src_prev_r;
  logic det_prev_r;
  logic src_tick;
  logic pin_low;
  logic uvr_low_v;
  logic det_out;
  logic soft_rst;
  logic [1:0] pin_cnt_r;
  logic pin_rst;
  logic [1:0] wdt_psc_r;
  logic [1:0] wdt_ctl_r;
  logic power_saving_bit_r;
  logic wdt_clr_r;
  logic uvr_dis_r;
  logic det_ie_r;
  logic [2:0] det_sel_r;
  logic det_flag_r;
  logic det_set;
  logic run_mode;
  logic low_mode;
  logic deep_mode;
  logic wdt_en;
  logic [31:0] wdt_cnt_r;
  logic [31:0] wdt_limit;
  logic wdt_rst;
  logic uvr_rst;
  logic sw_rst;
  logic any_rst;
  logic uvr_on;
  logic wr_option;
  logic wr_interrupt_flag_reg;
  logic wr_lvd;
  logic wr_auxiliary_ctrl_2;
  logic wr_auxiliary_ctrl_1;

  // Two-stage synchronisers for pin, oscillator and comparator inputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 4'hF;
      s2_r <= 4'hF;
    end else begin
      s1_r <= {pin_reset_n, slow_internal_oscillator, uv_reset_below,
               detect_below};
      s2_r <= s1_r;
    end
  end

  assign pin_low = !s2_r[3];
  assign uvr_low_v = s2_r[1];
  assign det_out = s2_r[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_prev_r <= 1'b1;
      det_prev_r <= 1'b0;
    end else begin
      src_prev_r <= s2_r[2];
      det_prev_r <= det_out;
    end
  end

  assign src_tick = s2_r[2] && !src_prev_r;
  assign soft_rst = (state_r == RVS_HOLD);

  assign wr_option = sfr_req.wr && sfr_req.addr == `RVS_ADDR_OPTION;
  assign wr_interrupt_flag_reg = sfr_req.wr && sfr_req.addr == `RVS_ADDR_INTERRUPT_FLAG_REG;
  assign wr_lvd = sfr_req.wr && sfr_req.addr == `RVS_ADDR_LVDCTL;
  assign wr_auxiliary_ctrl_2 = sfr_req.wr && sfr_req.addr == `RVS_ADDR_AUXILIARY_CTRL_2;
  assign wr_auxiliary_ctrl_1 = sfr_req.wr && sfr_req.addr == `RVS_ADDR_AUXILIARY_CTRL_1;
  assign sw_rst = sfr_req.wr && sfr_req.addr == `RVS_ADDR_SOFTWARE_COMMAND &&
                  sfr_req.wdata == `RVS_CMD_SW_RESET;

  assign run_mode = (power_mode == RVS_FAST) || (power_mode == RVS_SLOW);
  assign deep_mode = (power_mode == RVS_HALT) || (power_mode == RVS_STOP);
  assign low_mode = !run_mode;

  // Sequencer: warm-up, configuration load, run, reset hold.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= RVS_WARM;
      seq_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        RVS_WARM: begin
          if (seq_cnt_r >= WARMUP_CYCLES - 1) begin
            state_r <= RVS_LOAD;
            seq_cnt_r <= 32'h0;
          end else begin
            seq_cnt_r <= seq_cnt_r + 32'h1;
          end
        end
        RVS_LOAD: begin
          if (load_cnt_r == `RVS_CFG_BYTES && !load_rd_r) begin
            state_r <= RVS_RUN;
          end
        end
        RVS_RUN: begin
          if (any_rst) begin
            state_r <= RVS_HOLD;
            seq_cnt_r <= 32'h0;
          end
        end
        RVS_HOLD: begin
          if (seq_cnt_r >= `RVS_HOLD_CYCLES - 1) begin
            state_r <= RVS_LOAD;
            seq_cnt_r <= 32'h0;
          end else begin
            seq_cnt_r <= seq_cnt_r + 32'h1;
          end
        end
        default: begin
          state_r <= RVS_WARM;
          seq_cnt_r <= 32'h0;
        end
      endcase
    end
  end

  assign any_rst = pin_rst || sw_rst || wdt_rst || uvr_rst;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_rst_n <= 1'b0;
    end else begin
      sys_rst_n <= (state_r == RVS_RUN) && !any_rst;
    end
  end

  // Configuration read: six consecutive bytes, data sampled in the same cycle as the read.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      load_cnt_r <= 3'h0;
      load_rd_r <= 1'b0;
      load_addr_r <= `RVS_CFG_FIRST_ADDR;
      config_word_high <= `RVS_BYTE_ZERO;
    end else begin
      load_rd_r <= (state_r == RVS_LOAD) && load_cnt_r < `RVS_CFG_BYTES;
      if (state_r != RVS_LOAD) begin
        load_cnt_r <= 3'h0;
      end else if (load_cnt_r < `RVS_CFG_BYTES) begin
        load_cnt_r <= load_cnt_r + 3'h1;
      end
      load_addr_r <= `RVS_CFG_FIRST_ADDR + {13'h0, load_cnt_r};
      if (load_rd_r && load_addr_r == `RVS_CFG_HIGH_ADDR) begin
        config_word_high <= flash_rdata;
      end
    end
  end

  assign flash_rd = load_rd_r;
  assign flash_addr = load_addr_r;

  // Pin reset needs two slow oscillator edges seen while low.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_cnt_r <= 2'h0;
    end else if (!pin_low) begin
      pin_cnt_r <= 2'h0;
    end else if (src_tick && pin_cnt_r != `RVS_PIN_LOW_TICKS) begin
      pin_cnt_r <= pin_cnt_r + 2'h1;
    end
  end

  // The count clears one cycle after the pin rises, so gate on the level too.
  assign pin_rst = pin_cnt_r == `RVS_PIN_LOW_TICKS && pin_low &&
                   !config_word_high[`RVS_BIT_CFG_PIN_DIS];

  // Control registers; an internal reset returns them to defaults.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_psc_r <= 2'h0;
    end else if (soft_rst) begin
      wdt_psc_r <= 2'h0;
    end else if (wr_option) begin
      wdt_psc_r <= sfr_req.wdata[`RVS_BIT_WDT_PSC_HI:`RVS_BIT_WDT_PSC_LO];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_ctl_r <= 2'h0;
      power_saving_bit_r <= 1'b0;
    end else if (soft_rst) begin
      wdt_ctl_r <= 2'h0;
      power_saving_bit_r <= 1'b0;
    end else if (wr_auxiliary_ctrl_2) begin
      wdt_ctl_r <= sfr_req.wdata[`RVS_BIT_WATCHDOG_RESET_CONTROL_HI:`RVS_BIT_WATCHDOG_RESET_CONTROL_LO];
      power_saving_bit_r <= sfr_req.wdata[`RVS_BIT_POWER_SAVING_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_clr_r <= 1'b0;
      uvr_dis_r <= 1'b0;
    end else if (soft_rst) begin
      wdt_clr_r <= 1'b0;
      uvr_dis_r <= 1'b0;
    end else begin
      wdt_clr_r <= wr_auxiliary_ctrl_1 && sfr_req.wdata[`RVS_BIT_WDT_CLR];
      if (wr_auxiliary_ctrl_1) begin
        uvr_dis_r <= sfr_req.wdata[`RVS_BIT_UVR_DIS];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      det_ie_r <= 1'b0;
      det_sel_r <= 3'h0;
      internal_pull_supply_enable <= 1'b0;
    end else if (soft_rst) begin
      det_ie_r <= 1'b0;
      det_sel_r <= 3'h0;
      internal_pull_supply_enable <= 1'b0;
    end else if (wr_lvd) begin
      det_ie_r <= sfr_req.wdata[`RVS_BIT_DET_IE];
      det_sel_r <= sfr_req.wdata[`RVS_BIT_DET_SEL_HI:`RVS_BIT_DET_SEL_LO];
      if (sfr_req.wdata[`RVS_BIT_PULL_EN] || sysclk_slow_ok) begin
        internal_pull_supply_enable <= sfr_req.wdata[`RVS_BIT_PULL_EN];
      end
    end
  end

  // Detect flag: a new detection in the clearing cycle keeps the flag.
  assign det_set = det_out && !det_prev_r && uv_ctrl.detector_enable;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      det_flag_r <= 1'b0;
    end else if (soft_rst) begin
      det_flag_r <= 1'b0;
    end else if (det_set) begin
      det_flag_r <= 1'b1;
    end else if (wr_interrupt_flag_reg && sfr_req.wdata == `RVS_CMD_DET_CLEAR) begin
      det_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      detect_irq <= 1'b0;
    end else begin
      detect_irq <= det_flag_r && det_ie_r &&
                    extended_detect_irq_enable;
    end
  end

  // Watchdog runs on slow oscillator edges; period halves per select step.
  assign wdt_en = wdt_ctl_r[1] && (wdt_ctl_r[0] || run_mode);
  assign wdt_limit = WDT_MAX_TICKS >> wdt_psc_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_cnt_r <= 32'h0;
    end else if (soft_rst || wdt_clr_r || !wdt_en) begin
      wdt_cnt_r <= 32'h0;
    end else if (src_tick) begin
      wdt_cnt_r <= wdt_cnt_r + 32'h1;
    end
  end

  assign wdt_rst = wdt_en && wdt_cnt_r >= wdt_limit;

  // Undervoltage reset and detector enables by mode.
  assign uvr_on = !uvr_dis_r && !(power_saving_bit_r && low_mode);
  assign uvr_rst = uv_ctrl.uv_reset_enable && uvr_low_v;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uv_ctrl <= '0;
    end else begin
      uv_ctrl.uv_reset_enable <= uvr_on;
      uv_ctrl.por_only <= !uvr_on && !deep_mode;
      uv_ctrl.detector_enable <= uvr_on || !deep_mode;
      uv_ctrl.uv_reset_level <=
        config_word_high[`RVS_BIT_CFG_UVR_HI:`RVS_BIT_CFG_UVR_LO];
      uv_ctrl.detect_level <= det_sel_r;
    end
  end

  // Read data appears the cycle after the read strobe.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= `RVS_BYTE_ZERO;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        `RVS_ADDR_OPTION: sfr_rdata <= {2'h0, wdt_psc_r, 4'h0};
        `RVS_ADDR_INTERRUPT_FLAG_REG: sfr_rdata <= {det_flag_r, 7'h0};
        `RVS_ADDR_LVDCTL: sfr_rdata <= {det_ie_r, det_out, 2'h0, det_sel_r,
                                        internal_pull_supply_enable};
        `RVS_ADDR_AUXILIARY_CTRL_2: sfr_rdata <= {wdt_ctl_r, power_saving_bit_r, 5'h0};
        `RVS_ADDR_AUXILIARY_CTRL_1: sfr_rdata <= {wdt_clr_r, 3'h0, uvr_dis_r, 3'h0};
        default: sfr_rdata <= `RVS_BYTE_ZERO;
      endcase
    end
  end

  sequence s_sw_cmd;
    state_r == RVS_RUN && sw_rst;
  endsequence

  sequence s_hold_entry;
    state_r == RVS_HOLD && !sys_rst_n;
  endsequence

  AST_POWER_SAVING_BIT_OFF: assert property (
    power_saving_bit_r && low_mode |=> !uv_ctrl.uv_reset_enable)
    else $error("undervoltage reset on in low-power mode with saving set");
  AST_UVR_DISABLE: assert property (
    uvr_dis_r |=> !uv_ctrl.uv_reset_enable)
    else $error("undervoltage reset on while disabled");
  AST_UVR_LEVEL: assert property (
    ##1 uv_ctrl.uv_reset_level ==
      $past(config_word_high[`RVS_BIT_CFG_UVR_HI:`RVS_BIT_CFG_UVR_LO]))
    else $error("undervoltage level does not follow config");
  AST_IRQ_GATE: assert property (
    detect_irq |-> $past(det_flag_r && det_ie_r) &&
      $past(extended_detect_irq_enable))
    else $error("detect interrupt without both enables");
  AST_FLAG_CLEAR: assert property (
    wr_interrupt_flag_reg && sfr_req.wdata == `RVS_CMD_DET_CLEAR && !det_set
      |=> !det_flag_r)
    else $error("detect flag not cleared");
  AST_PULL_KEEP: assert property (
    wr_lvd && !sfr_req.wdata[`RVS_BIT_PULL_EN] && !sysclk_slow_ok &&
      internal_pull_supply_enable && !soft_rst
      |=> internal_pull_supply_enable)
    else $error("pull supply cleared on a fast clock");
  AST_WARM_HOLD: assert property (
    state_r == RVS_WARM |=> !sys_rst_n)
    else $error("reset released during warm-up");
  AST_PIN_REQ: assert property (
    pin_rst |-> pin_low && !config_word_high[`RVS_BIT_CFG_PIN_DIS])
    else $error("pin reset without qualified low level");
  AST_SW_RESET: assert property (
    s_sw_cmd |=> s_hold_entry)
    else $error("software command did not reset");
  AST_DEFAULTS: assert property (
    s_hold_entry |=> !uvr_dis_r && wdt_ctl_r == 2'h0 && !det_flag_r)
    else $error("registers not at defaults after reset");
  AST_WDT_OFF: assert property (
    !wdt_ctl_r[1] |-> !wdt_rst)
    else $error("watchdog reset while disabled");
  AST_WDT_CLEAR: assert property (
    wdt_clr_r |=> wdt_cnt_r == 32'h0 && !wdt_clr_r)
    else $error("watchdog clear failed");

endmodule : rvs_top

`default_nettype wire

// File: verification/rvs_tb.sv
// Self-checking testbench for the reset and voltage supervisor.
`timescale 1ns/1ps
`default_nettype none

module tb
  import rvs_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  rvs_sfr_req_t sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic [15:0] flash_addr;
  logic flash_rd;
  logic [7:0] flash_rdata = 8'h00;
  logic [7:0] cfg_byte = 8'h28;
  logic pin_reset_n = 1'b1;
  logic slow_osc = 1'b0;
  logic uv_below = 1'b0;
  logic det_below = 1'b0;
  rvs_mode_t mode = RVS_FAST;
  logic slow_ok = 1'b1;
  logic ext_ie = 1'b0;
  logic sys_rst_n;
  logic detect_irq;
  logic pull_en;
  rvs_uv_ctrl_t uv_ctrl;
  logic [7:0] config_word_high;
  int errors = 0;
  int total_checks = 0;
  int flash_reads = 0;

  always #2.5 clk = ~clk;

  // Flash answers for the address the block presents in the same cycle.
  always @(negedge clk) begin
    flash_rdata <= (flash_addr === 16'h7FFF) ? cfg_byte : 8'h3C;
    if (flash_rd === 1'b1) flash_reads <= flash_reads + 1;
  end

  rvs_top #(.WARMUP_CYCLES(20), .WDT_MAX_TICKS(32)) u_dut (
    .clk(clk),
    .arst_n(arst_n),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .flash_addr(flash_addr),
    .flash_rd(flash_rd),
    .flash_rdata(flash_rdata),
    .pin_reset_n(pin_reset_n),
    .slow_internal_oscillator(slow_osc),
    .uv_reset_below(uv_below),
    .detect_below(det_below),
    .power_mode(mode),
    .sysclk_slow_ok(slow_ok),
    .extended_detect_irq_enable(ext_ie),
    .sys_rst_n(sys_rst_n),
    .detect_irq(detect_irq),
    .internal_pull_supply_enable(pull_en),
    .uv_ctrl(uv_ctrl),
    .config_word_high(config_word_high)
  );

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    sfr_req.wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    sfr_req.rd = 1'b0;
    check(sfr_rdata, exp);
  endtask : rd_chk

  // Bounded wait for the chip reset output to reach a level.
  task automatic wait_rst(input logic v, input int n);
    int k;
    k = 0;
    while (sys_rst_n !== v && k < n) begin
      @(negedge clk);
      k++;
    end
    check(8'(sys_rst_n), 8'(v));
    if (sys_rst_n !== v) close_out();
  endtask : wait_rst

  task automatic tick(input int n);
    repeat (n) begin
      slow_osc = 1'b1;
      step(3);
      slow_osc = 1'b0;
      step(3);
    end
  endtask : tick

  task automatic sw_reset();
    wr(8'h97, 8'h56);
    wait_rst(1'b0, 5);
    wait_rst(1'b1, 80);
  endtask : sw_reset

  task automatic t_power_on();
    step(18);
    check(8'(sys_rst_n), 8'h00);
    wait_rst(1'b1, 60);
    check(config_word_high, 8'h28);
    check(8'(flash_reads), 8'h06);
    rd_chk(8'h94, 8'h00);
    rd_chk(8'hBF, 8'h00);
    rd_chk(8'hF8, 8'h00);
    $display("power-on test done");
  endtask : t_power_on

  task automatic t_regs();
    wr(8'h94, 8'hFF);
    rd_chk(8'h94, 8'h30);
    rd_chk(8'h90, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'hBF, {4'h0, 3'(i), 1'b0});
      check(8'(uv_ctrl.detect_level), 8'(i));
    end
    wr(8'hF7, 8'h20);
    sw_reset();
    rd_chk(8'hF7, 8'h00);
    rd_chk(8'h94, 8'h00);
    wr(8'h97, 8'h55);
    step(3);
    check(8'(sys_rst_n), 8'h01);
    for (int i = 0; i < 8; i++) begin
      cfg_byte = {2'b00, 3'(i), 3'b000};
      sw_reset();
      check(8'(uv_ctrl.uv_reset_level), 8'(i));
    end
    cfg_byte = 8'h28;
    sw_reset();
    $display("register test done");
  endtask : t_regs

  task automatic t_uv_modes();
    logic off;
    wr(8'hBF, 8'h01);
    for (int d = 0; d < 2; d++) begin
      for (int p = 0; p < 2; p++) begin
        for (int m = 0; m < 5; m++) begin
          wr(8'hF7, {2'b00, 1'(p), 5'h00});
          wr(8'hF8, {4'h0, 1'(d), 3'h0});
          mode = rvs_mode_t'(3'(m));
          step(3);
          off = (d == 1) || (p == 1 && m >= 2);
          check(8'(uv_ctrl.uv_reset_enable), 8'(!off));
          check(8'(uv_ctrl.detector_enable), 8'(!(off && m >= 3)));
          check(8'(uv_ctrl.por_only), 8'(off && m <= 2));
        end
      end
    end
    mode = RVS_FAST;
    uv_below = 1'b1;
    step(10);
    check(8'(sys_rst_n), 8'h01);
    wr(8'hF8, 8'h00);
    wait_rst(1'b0, 10);
    uv_below = 1'b0;
    wait_rst(1'b1, 80);
    $display("undervoltage test done");
  endtask : t_uv_modes

  task automatic t_detect();
    ext_ie = 1'b1;
    det_below = 1'b1;
    step(6);
    check(8'(detect_irq), 8'h00);
    rd_chk(8'h95, 8'h80);
    wr(8'hBF, 8'h80);
    step(2);
    check(8'(detect_irq), 8'h01);
    rd_chk(8'hBF, 8'hC0);
    ext_ie = 1'b0;
    step(3);
    check(8'(detect_irq), 8'h00);
    wr(8'h95, 8'h00);
    rd_chk(8'h95, 8'h80);
    det_below = 1'b0;
    wr(8'h95, 8'h7F);
    rd_chk(8'h95, 8'h00);
    rd_chk(8'hBF, 8'h80);
    ext_ie = 1'b1;
    step(3);
    check(8'(detect_irq), 8'h00);
    wr(8'hBF, 8'h00);
    $display("detect test done");
  endtask : t_detect

  task automatic t_pull();
    wr(8'hBF, 8'h01);
    check(8'(pull_en), 8'h01);
    slow_ok = 1'b0;
    wr(8'hBF, 8'h00);
    check(8'(pull_en), 8'h01);
    slow_ok = 1'b1;
    wr(8'hBF, 8'h00);
    check(8'(pull_en), 8'h00);
    $display("pull supply test done");
  endtask : t_pull

  task automatic t_pin();
    pin_reset_n = 1'b0;
    tick(1);
    pin_reset_n = 1'b1;
    step(6);
    check(8'(sys_rst_n), 8'h01);
    pin_reset_n = 1'b0;
    tick(3);
    check(8'(sys_rst_n), 8'h00);
    pin_reset_n = 1'b1;
    wait_rst(1'b1, 80);
    cfg_byte = 8'h68;
    sw_reset();
    pin_reset_n = 1'b0;
    tick(4);
    check(8'(sys_rst_n), 8'h01);
    pin_reset_n = 1'b1;
    cfg_byte = 8'h28;
    sw_reset();
    $display("pin reset test done");
  endtask : t_pin

  task automatic t_wdt();
    wr(8'h94, 8'h30);
    wr(8'hF7, 8'hC0);
    tick(3);
    wr(8'hF8, 8'h80);
    rd_chk(8'hF8, 8'h00);
    tick(3);
    check(8'(sys_rst_n), 8'h01);
    tick(1);
    wait_rst(1'b0, 10);
    wait_rst(1'b1, 80);
    for (int p = 0; p < 4; p++) begin
      wr(8'h94, {2'b00, 2'(p), 4'h0});
      wr(8'hF7, 8'hC0);
      tick((32 >> p) - 1);
      check(8'(sys_rst_n), 8'h01);
      tick(1);
      wait_rst(1'b0, 10);
      wait_rst(1'b1, 80);
    end
    wr(8'h94, 8'h30);
    wr(8'hF7, 8'h80);
    mode = RVS_IDLE;
    tick(6);
    check(8'(sys_rst_n), 8'h01);
    mode = RVS_FAST;
    tick(4);
    wait_rst(1'b0, 10);
    wait_rst(1'b1, 80);
    tick(6);
    check(8'(sys_rst_n), 8'h01);
    wr(8'h94, 8'h30);
    wr(8'hF7, 8'hC0);
    wr(8'hBF, 8'h01);
    mode = RVS_STOP;
    tick(4);
    wait_rst(1'b0, 10);
    mode = RVS_FAST;
    wait_rst(1'b1, 80);
    $display("watchdog test done");
  endtask : t_wdt

  initial begin
    step(5);
    arst_n = 1'b1;
    t_power_on();
    t_regs();
    t_uv_modes();
    t_detect();
    t_pull();
    t_pin();
    t_wdt();
    close_out();
  end
endmodule : tb

`default_nettype wire
